//--- rtl/flash_seq_pkg.sv
// Purpose: Shared constants and types for the flash program/erase sequencer
// Assumes: APB slave with 32-bit data and 12-bit byte address
// Notes: Control bits follow the order of ctrl_t, highest field first
package flash_seq_pkg;

   // ==========================================================
   // Bus and register map
   // ==========================================================
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] OFS_BLOCK = 12'h004;
   localparam logic [APB_AW-1:0] OFS_ADDR = 12'h008;
   localparam logic [APB_AW-1:0] OFS_DATA = 12'h00C;
   localparam logic [APB_AW-1:0] OFS_STATUS = 12'h010;
   localparam int CTRL_W = 7;
   localparam int CTRL_PIN_BIT = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

   // ==========================================================
   // Flash array geometry
   // ==========================================================
   localparam int FADDR_W = 24;
   localparam int BLOCK_W = 8;
   localparam int VDATA_W = 16;
   localparam int PAGE_BYTES = 32;
   localparam int IDX_W = 5;
   localparam int FILL_W = 6;
   localparam logic [FILL_W-1:0] FILL_FULL = 6'h20;
   localparam logic [FADDR_W-1:0] VERIFY_STEP = 24'h000002;
   localparam logic [FADDR_W-1:0] BYTE_STEP = 24'h000001;
   localparam logic [IDX_W-1:0] PAGE_ALIGN = 5'h00;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic ev;
      logic pv;
      logic erase;
      logic prog;
      logic erase_setup_bit;
      logic program_setup_bit;
      logic software_write_enable;
   } ctrl_t;

   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_PROG_SETUP,
      MODE_PROGRAM,
      MODE_ERASE_SETUP,
      MODE_ERASE,
      MODE_PROG_VERIFY,
      MODE_ERASE_VERIFY
   } mode_t;

   typedef struct packed {
      logic [FADDR_W-1:0] addr;
      logic [BLOCK_W-1:0] blocks;
      logic program_pulse;
      logic erase_pulse;
      logic verify;
   } array_ctl_t;

   // Mode follows the control bits; pulses need the flag and the pin high
   function automatic mode_t mode_of(input ctrl_t c, input logic pin_high);
      mode_t m;
      m = MODE_IDLE;
      if (c.software_write_enable && c.pv)
         m = MODE_PROG_VERIFY;
      else if (c.software_write_enable && c.ev)
         m = MODE_ERASE_VERIFY;
      else if (c.software_write_enable && c.program_setup_bit)
         m = (c.prog && pin_high) ? MODE_PROGRAM : MODE_PROG_SETUP;
      else if (c.software_write_enable && c.erase_setup_bit)
         m = (c.erase && pin_high) ? MODE_ERASE : MODE_ERASE_SETUP;
      return m;
   endfunction : mode_of

endpackage : flash_seq_pkg

//--- rtl/page_latch.sv
// Purpose: Holds the 32 program bytes written by the controller
// Assumes: One byte write per cycle at most
// Notes: Fill count saturates at a full page
module page_latch
   import flash_seq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Byte writes
   input wire logic clear,
   input wire logic we,
   input wire logic [IDX_W-1:0] idx,
   input wire logic [7:0] wbyte,
   // Page contents
   output logic [PAGE_BYTES-1:0][7:0] page_data,
   output logic [FILL_W-1:0] fill
);

   typedef struct packed {
      logic [PAGE_BYTES-1:0][7:0] mem;
      logic [FILL_W-1:0] fill;
   } latch_state_t;

   latch_state_t s;
   latch_state_t next_s;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      next_s = s;
      if (clear)
         next_s.fill = '0;
      if (we)
      begin
         next_s.mem[idx] = wbyte;
         if (s.fill != FILL_FULL)
            next_s.fill = s.fill + 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign page_data = s.mem;
   assign fill = s.fill;

endmodule : page_latch

//--- rtl/flash_seq.sv
// Purpose: Flash program/erase sequencer with APB control registers
// Assumes: Array macro and guard timer run on pclk; write-enable pin is asynchronous
// Notes: Wait times and retry limits are kept by software
//
// What this block and its controller do
// RL1: Four flash modes entered only through setup, pulse and verify control bits.
// RL2: Array data reads are refused while a program or erase pulse runs.
// RL3: Program or erase pulses only with the pin high and software enable set.
// RL4: Controller toggles control bits only from code outside flash.
// RL5: Controller programs exactly 32 bytes per sequence.
// RL6: First address of each unit is 32-byte aligned in its low byte.
// RL7: After enable wait, 32 consecutive bytes are written; addresses and data latched.
// RL8: Unused bytes of a short unit are written as all ones.
// RL9: Controller arms the guard timer longer than the program waits.
// RL10: Set program setup, wait, then set the program bit.
// RL11: Program bit stays set no longer than one pulse time.
// RL12: Clear program bit, wait, then clear program setup to leave.
// RL13: Leaving program mode clears the guard timer setting.
// RL14: Verify dummy write latches address; 16-bit verify data returned for it.
// RL15: After 32 verified bytes, reprogram from computed data, at most N times.
// RL16: Controller keeps original and reprogram data buffers in RAM.
// RL17: Erase one block, selected after the enable wait.
// RL18: Arm guard, set erase setup, wait, then set erase bit.
// RL19: Erase bit stays set no longer than one erase time; no preprogram.
// RL20: Clear erase, wait, clear erase setup; device clears guard setting.
// RL21: Erase-verify advances on all ones, else re-erase at most N times.
module flash_seq
   import flash_seq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Write-enable pin
   input wire logic write_enable_pin,
   // Flash array macro
   output array_ctl_t array_ctl,
   output logic [PAGE_BYTES-1:0][7:0] page_data,
   input wire logic [VDATA_W-1:0] array_rdata,
   // Runaway guard timer
   output logic guard_disarm
);

   typedef struct packed {
      logic pin_meta;
      logic pin;
      ctrl_t ctrl;
      logic [BLOCK_W-1:0] blocks;
      logic [FADDR_W-1:0] addr;
      logic [FADDR_W-1:0] page_base;
      logic [FADDR_W-1:0] verify_addr;
      logic [VDATA_W-1:0] vdata;
      mode_t mode;
      array_ctl_t arr;
      logic disarm;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } seq_state_t;

   seq_state_t s;
   seq_state_t next_s;
   logic access;
   logic verifying;
   logic pulsing;
   logic latch_we;
   logic latch_clear;
   logic [FILL_W-1:0] fill;

   // ==========================================================
   // Mode decoding
   // ==========================================================
   // Array reads are refused while either pulse runs
   function automatic logic is_pulse(input mode_t m);
      return (m == MODE_PROGRAM) || (m == MODE_ERASE);
   endfunction : is_pulse

   // Dummy writes and verify reads belong to both verify modes
   function automatic logic is_verify(input mode_t m);
      return (m == MODE_PROG_VERIFY) || (m == MODE_ERASE_VERIFY);
   endfunction : is_verify

   // ==========================================================
   // Page latch
   // ==========================================================
   page_latch u_page_latch (
      .pclk(pclk),
      .presetn(presetn),
      .clear(latch_clear),
      .we(latch_we),
      .idx(s.addr[IDX_W-1:0]),
      .wbyte(pwdata[7:0]),
      .page_data(page_data),
      .fill(fill)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      next_s = s;
      access = psel && penable && !s.ready;
      verifying = is_verify(s.mode);
      pulsing = is_pulse(s.mode);
      latch_we = 1'b0;
      latch_clear = 1'b0;

      // Pin passes two flops before use
      next_s.pin_meta = write_enable_pin;
      next_s.pin = s.pin_meta;

      // One wait state: data and pready leave flops together
      next_s.ready = access;
      next_s.err = 1'b0;
      next_s.rdata = '0;
      next_s.disarm = 1'b0;

      // ==========================================================
      // Register writes and reads
      // ==========================================================
      if (access && pwrite)
      begin
         unique case (paddr)
            OFS_CTRL:
               next_s.ctrl = ctrl_t'(pwdata[CTRL_W-1:0]); // RL1
            OFS_BLOCK:
               next_s.blocks = pwdata[BLOCK_W-1:0]; // RL17
            OFS_ADDR:
            begin
               next_s.addr = pwdata[FADDR_W-1:0];
               latch_clear = 1'b1;
            end
            OFS_DATA:
            begin
               if (verifying)
               begin
                  // Dummy write fixes the address to be verified
                  next_s.verify_addr = s.addr; // RL14
                  next_s.addr = s.addr + VERIFY_STEP;
               end
               else if (!pulsing && s.ctrl.software_write_enable)
               begin
                  latch_we = 1'b1; // RL7
                  if (fill == '0)
                     next_s.page_base = {s.addr[FADDR_W-1:IDX_W], PAGE_ALIGN};
                  next_s.addr = s.addr + BYTE_STEP;
               end
            end
            default:
               next_s.err = 1'b1;
         endcase
      end
      else if (access)
      begin
         unique case (paddr)
            OFS_CTRL:
               next_s.rdata = {24'h000000, s.pin, s.ctrl};
            OFS_BLOCK:
               next_s.rdata = {24'h000000, s.blocks};
            OFS_ADDR:
               next_s.rdata = {8'h00, s.addr};
            OFS_DATA:
            begin
               if (pulsing)
                  next_s.err = 1'b1; // RL2
               else
                  next_s.rdata = {16'h0000, s.vdata}; // RL14
            end
            OFS_STATUS:
               next_s.rdata = {23'h000000, fill, s.mode};
            default:
               next_s.err = 1'b1;
         endcase
      end

      // ==========================================================
      // Verify data, guard release, mode and array controls
      // ==========================================================
      // Verify data of the latched address, only in the verify modes
      if (verifying)
         next_s.vdata = array_rdata; // RL14

      // Dropping a setup bit ends the mode and releases the guard
      if ((s.ctrl.program_setup_bit && !next_s.ctrl.program_setup_bit) || (s.ctrl.erase_setup_bit && !next_s.ctrl.erase_setup_bit))
         next_s.disarm = 1'b1; // RL13 RL20

      next_s.mode = mode_of(next_s.ctrl, s.pin); // RL1 RL3

      // Array controls follow the registered mode
      next_s.arr.program_pulse = (s.mode == MODE_PROGRAM); // RL3
      next_s.arr.erase_pulse = (s.mode == MODE_ERASE) && (s.blocks != '0); // RL3 RL17
      next_s.arr.verify = verifying;
      next_s.arr.blocks = s.blocks;
      next_s.arr.addr = verifying ? s.verify_addr : s.page_base;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.ctrl <= ctrl_t'(CTRL_RESET);
         s.mode <= MODE_IDLE;
      end
      else
         s <= next_s;
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign array_ctl = s.arr;
   assign guard_disarm = s.disarm;

endmodule : flash_seq

//--- test/flash_array_model.sv
// Purpose: Flash array model answering verify reads
// Assumes: Same clock as the sequencer
// Notes: Outside verify the data toggles every cycle
module flash_array_model
   import flash_seq_pkg::*;
(
   // Clock and array
   input wire logic pclk,
   input wire array_ctl_t array_ctl,
   output logic [VDATA_W-1:0] array_rdata = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge pclk)
      array_rdata <= array_ctl.verify ? (array_ctl.addr[15:0] ^ 16'hA5C3) : ~array_rdata;
endmodule : flash_array_model

//--- test/flash_seq_assertions.sv
// Purpose: Port checks of the flash sequencer
// Assumes: One clock, active low reset
// Notes: Bound to flash_seq
module flash_seq_assertions
   import flash_seq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus, pin, array
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic write_enable_pin,
   input wire array_ctl_t array_ctl,
   input wire logic guard_disarm
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic take;
   logic ctrl_wr;
   assign take = psel && penable && !pready;
   assign ctrl_wr = take && pwrite && paddr == OFS_CTRL;
   chk_ready_next: assert property (take |=> pready ##1 !pready)
      else $error("Bad ready timing");
   chk_unmapped_err: assert property (take && paddr > OFS_STATUS |=> pslverr && prdata == 32'h0)
      else $error("Unmapped not refused");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("Error without ready");
   chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
      else $error("Read data outside answer");
   chk_pin_low: assert property (!write_enable_pin [*8] |-> !array_ctl.program_pulse && !array_ctl.erase_pulse)
      else $error("Pulse with pin low");
   chk_pulse_excl: assert property (array_ctl.program_pulse |-> !array_ctl.erase_pulse && !array_ctl.verify)
      else $error("Modes overlap");
   chk_erase_block: assert property (array_ctl.erase_pulse |-> array_ctl.blocks != 8'h00)
      else $error("Erase without block");
   chk_disarm_cause: assert property (guard_disarm |-> $past(ctrl_wr, 1))
      else $error("Disarm without control write");
   chk_disarm_single: assert property ($rose(guard_disarm) |=> !guard_disarm)
      else $error("Disarm too long");
endmodule : flash_seq_assertions
bind flash_seq flash_seq_assertions u_flash_seq_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .write_enable_pin(write_enable_pin), .array_ctl(array_ctl), .guard_disarm(guard_disarm));

//--- test/test_flash_seq.sv
// Purpose: Self-checking bench of the flash sequencer
// Assumes: Array model answers verify reads
// Notes: Random values from a fixed shift register seed
module test_flash_seq
   import flash_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
   logic [APB_AW-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, r, lfsr = 32'h5D6C;
   logic pready, pslverr, guard_disarm, err;
   array_ctl_t actl;
   logic [PAGE_BYTES-1:0][7:0] page_data;
   logic [VDATA_W-1:0] ardata;
   logic [FADDR_W-1:0] base;
   logic [7:0] b[PAGE_BYTES], blk;
   logic [6:0] c;
   logic [6:0] corner[5] = '{7'h0B, 7'h15, 7'h0A, 7'h61, 7'h41};
   int failures = 0, n_compared = 0, disarms = 0, d0;
   always #10 pclk = ~pclk;
   always @(posedge pclk)
      if (guard_disarm === 1'b1)
         disarms <= disarms + 1;
   flash_seq u_flash_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_enable_pin(pin), .array_ctl(actl), .page_data(page_data), .array_rdata(ardata),
      .guard_disarm(guard_disarm));
   flash_array_model u_flash_array_model (.pclk(pclk), .array_ctl(actl), .array_rdata(ardata));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   // Bits: swe psu esu prog erase pv ev
   function automatic logic [2:0] exp_mode(input logic [6:0] k, input logic p);
      if (!k[0])
         return 3'h0;
      if (k[5])
         return 3'h5;
      if (k[6])
         return 3'h6;
      if (k[1])
         return (k[3] && p) ? 3'h2 : 3'h1;
      if (k[2])
         return (k[4] && p) ? 3'h4 : 3'h3;
      return 3'h0;
   endfunction : exp_mode
   task automatic print_verdict();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 9);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n > 8)
      begin
         failures++;
         print_verdict();
      end
   endtask : apb
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, OFS_CTRL, 32'h0);
         r = rnd();
         c = (i < 5) ? corner[i] : r[6:0];
         pin <= (i < 5) | r[9];
         repeat (4) @(posedge pclk);
         apb(1'b1, OFS_CTRL, {25'h0, c});
         apb(1'b0, OFS_CTRL, 32'h0);
         chk(rd, {24'h0, pin, c}, "ctrl");
         apb(1'b0, OFS_STATUS, 32'h0);
         chk({29'h0, rd[2:0]}, {29'h0, exp_mode(c, pin)}, "mode");
      end
      pin <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h1);
      r = rnd();
      base = {r[23:5], 5'h00};
      apb(1'b1, OFS_ADDR, {8'h0, base});
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
         r = rnd();
         b[i] = (i > 27) ? 8'hFF : r[7:0];
         apb(1'b1, OFS_DATA, {24'h0, b[i]});
      end
      for (int i = 0; i < PAGE_BYTES; i++)
         chk({24'h0, page_data[i]}, {24'h0, b[i]}, "page");
      apb(1'b0, OFS_ADDR, 32'h0);
      chk(rd, {8'h0, base + 24'(PAGE_BYTES)}, "addr");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({26'h0, rd[8:3]}, 32'h20, "fill");
      chk({8'h0, actl.addr}, {8'h0, base}, "base");
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b1, OFS_CTRL, 32'hB);
      repeat (2) @(posedge pclk);
      chk({31'h0, actl.program_pulse}, 32'h1, "prog");
      apb(1'b0, OFS_DATA, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000, "busy");
      d0 = disarms;
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (4) @(posedge pclk);
      chk(disarms - d0, 1, "disarm");
      apb(1'b1, OFS_CTRL, 32'h21);
      apb(1'b1, OFS_ADDR, {8'h0, base});
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, OFS_DATA, 32'hFF);
         repeat (3) @(posedge pclk);
         chk({8'h0, actl.addr}, {8'h0, base + 24'(2 * i)}, "vaddr");
         apb(1'b0, OFS_DATA, 32'h0);
         chk(rd, {16'h0, (base[15:0] + 16'(2 * i)) ^ 16'hA5C3}, "vdata");
      end
      apb(1'b1, OFS_CTRL, 32'h1);
      r = rnd();
      blk = r[7:0] | 8'h01;
      apb(1'b1, OFS_BLOCK, {24'h0, blk});
      apb(1'b0, OFS_BLOCK, 32'h0);
      chk(rd, {24'h0, blk}, "block");
      apb(1'b1, OFS_CTRL, 32'h5);
      apb(1'b1, OFS_CTRL, 32'h15);
      repeat (2) @(posedge pclk);
      chk({23'h0, actl.erase_pulse, actl.blocks}, {23'h1, blk}, "erase");
      d0 = disarms;
      apb(1'b1, OFS_CTRL, 32'h5);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (4) @(posedge pclk);
      chk(disarms - d0, 1, "edisarm");
      apb(1'b1, OFS_CTRL, 32'h41);
      apb(1'b1, OFS_ADDR, {8'h0, base});
      apb(1'b1, OFS_DATA, 32'hFF);
      repeat (3) @(posedge pclk);
      chk({8'h0, actl.addr}, {8'h0, base}, "evaddr");
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, {16'h0, base[15:0] ^ 16'hA5C3}, "evdata");
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, 12'h014, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      print_verdict();
   end
endmodule : test_flash_seq
